// ==== pkg/tmc_pkg.sv ====
// Constants, field layout and state types of the main control register.
// Assumes a single 40 MHz clock and a three-wire serial host on pins.
package tmc_pkg;
  localparam int           DATA_W        = 32;
  localparam int           LVL_W         = 6;
  localparam logic [3:0]   ADDR_MAIN     = 4'h4;
  localparam logic         RW_WRITE      = 1'b1;
  localparam logic [5:0]   HDR_LAST      = 6'h04;
  localparam logic [5:0]   DATA_LEN      = 6'h20;
  localparam logic [5:0]   CNT_SAT       = 6'h21;
  localparam logic [31:0]  DATA_TOP      = 32'h8000_0000;
  localparam logic [31:0]  CTRL_RESET    = 32'h1000_0270;
  localparam logic [31:0]  CTRL_WRITABLE = 32'hffff_fbf2;
  localparam int POS_PWR  = 31;
  localparam int POS_DIR  = 30;
  localparam int POS_CLK  = 29;
  localparam int POS_LOCK = 28;
  localparam int POS_AMP  = 27;
  localparam int POS_WAKE = 26;
  localparam int POS_LNA  = 25;
  localparam int POS_MEAS = 24;
  localparam int POS_THR  = 18;
  localparam int WID_THR  = 6;
  localparam int POS_HYS  = 15;
  localparam int WID_HYS  = 3;
  localparam int POS_LVL  = 12;
  localparam int WID_LVL  = 3;
  localparam int POS_TRANSMIT_FREQ_PAIR_SELECT = 11;
  localparam int POS_RECEIVE_FREQ_SELECT = 8;
  localparam int WID_RECEIVE_FREQ_SELECT = 2;
  localparam int POS_XTAL = 7;
  localparam int POS_BW   = 6;
  localparam int POS_POL  = 5;
  localparam int POS_SREF = 4;
  localparam int POS_ADCS = 1;
  localparam logic [1:0] PAIR_LO_A = 2'h0;
  localparam logic [1:0] PAIR_LO_B = 2'h1;
  localparam logic [1:0] PAIR_HI_A = 2'h2;
  localparam logic [1:0] PAIR_HI_B = 2'h3;
  typedef enum {SER_IDLE, SER_HDR, SER_WR, SER_RD} tmc_ser_e;
endpackage

// ==== pkg/tmc_ser_if.sv ====
// Carrier between the serial front end and the register core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tmc_ser_if;
  logic        wr_stb;
  logic [31:0] wr_val;
  logic [31:0] wr_mask;
  logic [31:0] rd_val;
  modport ser  (output wr_stb, output wr_val, output wr_mask, input rd_val);
  modport core (input wr_stb, input wr_val, input wr_mask, output rd_val);
endinterface
`default_nettype wire

// ==== design/tmc_serial.sv ====
// Serial front end: header, write shifting and read shifting.
// Assumes pin inputs already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module tmc_serial import tmc_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sle_s,
  input  wire logic sck_s,
  input  wire logic sdi_s,
  output logic      sdo,
  output logic      sdo_oe,
  tmc_ser_if.ser    bus
);
  tmc_ser_e    st_ff, nxt_st;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic [4:0]  hdr_ff, nxt_hdr;
  logic [31:0] val_ff, nxt_val, mask_ff, nxt_mask, sel;
  logic        stb_ff, nxt_stb, sdo_ff, nxt_sdo, oe_ff, nxt_oe;
  logic        prev_ff, rise, fall, hit;

  always_comb begin
    nxt_st = st_ff;  nxt_cnt = cnt_ff;  nxt_hdr = hdr_ff;
    nxt_val = val_ff;  nxt_mask = mask_ff;  nxt_stb = 1'b0;
    nxt_sdo = sdo_ff;  nxt_oe = oe_ff;
    rise = sck_s & ~prev_ff;
    fall = ~sck_s & prev_ff;
    hit  = (hdr_ff[4:1] == ADDR_MAIN);
    sel  = DATA_TOP >> cnt_ff[4:0];
    if (sle_s) begin
      if (st_ff == SER_WR && cnt_ff != '0 && cnt_ff <= DATA_LEN) nxt_stb = hit;
      nxt_st = SER_IDLE;
      nxt_oe = 1'b0;
      nxt_sdo = 1'b0;
    end else begin
      case (st_ff)
        SER_IDLE: begin
          nxt_st = SER_HDR;
          nxt_cnt = '0;
          nxt_mask = '0;
        end
        SER_HDR: if (rise) begin
          nxt_hdr = {hdr_ff[3:0], sdi_s};
          if (cnt_ff == HDR_LAST) begin
            nxt_cnt = '0;
            nxt_st = (sdi_s == RW_WRITE) ? SER_WR : SER_RD;
          end else nxt_cnt = cnt_ff + 6'h01;
        end
        SER_WR: if (rise && cnt_ff < DATA_LEN) begin
          nxt_val = sdi_s ? (val_ff | sel) : (val_ff & ~sel);
          nxt_mask = mask_ff | sel;
          nxt_cnt = cnt_ff + 6'h01;
        end else if (rise && cnt_ff == DATA_LEN) begin
          // Overlong write commits on first extra edge
          nxt_stb = hit;
          nxt_cnt = CNT_SAT;
        end
        SER_RD: if (fall) begin
          nxt_oe = 1'b1;
          nxt_sdo = (cnt_ff < DATA_LEN) ? (hit ? |(bus.rd_val & sel) : 1'b1) : 1'b0;
          if (cnt_ff < CNT_SAT) nxt_cnt = cnt_ff + 6'h01;
        end
        default: nxt_st = SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= SER_IDLE;  cnt_ff <= '0;  hdr_ff <= '0;  val_ff <= '0;
      mask_ff <= '0;  stb_ff <= 1'b0;  sdo_ff <= 1'b0;  oe_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;  cnt_ff <= nxt_cnt;  hdr_ff <= nxt_hdr;  val_ff <= nxt_val;
      mask_ff <= nxt_mask;  stb_ff <= nxt_stb;  sdo_ff <= nxt_sdo;  oe_ff <= nxt_oe;
      prev_ff <= sck_s;
    end
  end

  assign bus.wr_stb  = stb_ff;
  assign bus.wr_val  = val_ff;
  assign bus.wr_mask = mask_ff;
  assign sdo         = sdo_ff;
  assign sdo_oe      = oe_ff;

  AST_OE_IDLE: assert property (@(posedge clk) disable iff (rst)
    (sle_s && ce) |=> !sdo_oe) else $error("data pin driven while enable inactive");
endmodule // tmc_serial
`default_nettype wire

// ==== design/tmc_rssi_gate.sv ====
// Hysteresis gate deciding whether demodulated data may pass.
// Assumes one strobe per fresh signal level result.
`timescale 1ns/1ps
`default_nettype none
module tmc_rssi_gate import tmc_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             meas_stb,
  input  wire logic [LVL_W-1:0] level,
  input  wire logic [5:0]       thr,
  input  wire logic [2:0]       hys,
  output logic                  pass
);
  logic       pass_ff, nxt_pass;
  logic [6:0] hi_lvl, lvl_up;

  // Low side compared as level+hys < thr so it never goes negative
  always_comb begin
    hi_lvl = {1'b0, thr} + {4'h0, hys};
    lvl_up = {1'b0, level} + {4'h0, hys};
    nxt_pass = pass_ff;
    if (meas_stb) begin
      if ({1'b0, level} >= hi_lvl) nxt_pass = 1'b1;
      else if (lvl_up < {1'b0, thr}) nxt_pass = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) pass_ff <= 1'b0;
    else if (ce) pass_ff <= nxt_pass;
  end

  assign pass = pass_ff;

  AST_GATE_HIGH: assert property (@(posedge clk) disable iff (rst)
    (ce && meas_stb && {1'b0, level} >= hi_lvl) |=> pass) else $error("gate not opened");
  AST_GATE_MID: assert property (@(posedge clk) disable iff (rst)
    (ce && meas_stb && {1'b0, level} < hi_lvl && lvl_up >= {1'b0, thr}) |=> $stable(pass))
    else $error("gate moved inside hysteresis band");
endmodule // tmc_rssi_gate
`default_nettype wire

// ==== design/tmc_top.sv ====
// Main control register of the transceiver, its serial access and field decode.
// Assumes pins from the host are asynchronous; PLL, ADC and demodulator are on clk.
`timescale 1ns/1ps
`default_nettype none
module tmc_top import tmc_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             sle_pin,
  input  wire logic             sck_pin,
  input  wire logic             sdata_pin_in,
  output logic                  sdata_pin_out,
  output logic                  sdata_pin_oe,
  input  wire logic             synth_lock_flag,
  input  wire logic             recovered_clk_in,
  input  wire logic             adc_valid,
  input  wire logic [LVL_W-1:0] adc_level,
  input  wire logic             demod_raw,
  output logic                  power_on,
  output logic                  tx_mode,
  output logic                  recovered_clk_pin,
  output logic                  transmit_gate,
  output logic                  amp_on,
  output logic                  wakeup_run,
  output logic                  lna_min_gain,
  output logic                  adc_supply_route,
  output logic                  adc_disc_source,
  output logic [LVL_W-1:0]      measured_signal_level,
  output logic [LVL_W-1:0]      supply_level,
  output logic                  demod_data_pin,
  output logic [2:0]            output_power_level,
  output logic [1:0]            tx_freq_code_a,
  output logic [1:0]            tx_freq_code_b,
  output logic [1:0]            rx_freq_code,
  output logic                  crystal_high,
  output logic                  discriminator_standard,
  output logic                  slicer_internal
);
  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  function automatic logic [5:0] fld(input logic [31:0] r, input int lo, input int w);
    logic [31:0] m;
    m = (32'h0000_0001 << w) - 32'h0000_0001;
    fld = 6'((r >> lo) & m);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pin_raw, meta_ff, nxt_meta, sync_ff, nxt_sync;
  assign pin_raw = {sle_pin, sck_pin, sdata_pin_in};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_comb begin
        nxt_meta[g] = pin_raw[g];
        nxt_sync[g] = meta_ff[g];
      end
    end
  endgenerate

  // Enable pin idles high so the port looks inhibited out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 3'h4;
      sync_ff <= 3'h4;
    end else if (ce) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------------
  tmc_ser_if ser_bus ();

  tmc_serial u_serial (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .sle_s  (sync_ff[2]),
    .sck_s  (sync_ff[1]),
    .sdi_s  (sync_ff[0]),
    .sdo    (sdata_pin_out),
    .sdo_oe (sdata_pin_oe),
    .bus    (ser_bus.ser)
  );

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_ff, nxt_ctrl, wr_keep;

  always_comb begin
    wr_keep = ser_bus.wr_mask & CTRL_WRITABLE;
    nxt_ctrl = ctrl_ff;
    if (ser_bus.wr_stb) nxt_ctrl = (ctrl_ff & ~wr_keep) | (ser_bus.wr_val & wr_keep);
  end

  always_ff @(posedge clk) begin
    if (rst) ctrl_ff <= CTRL_RESET;
    else if (ce) ctrl_ff <= nxt_ctrl;
  end

  assign ser_bus.rd_val = ctrl_ff;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  logic       pwr, dir, lock_only, meas_sel;
  logic       nxt_power, nxt_tx, nxt_clkpin, nxt_txgate, nxt_amp, nxt_wake;
  logic       nxt_lna, nxt_route, nxt_disc, nxt_xtal, nxt_bw, nxt_sref;
  logic [2:0] nxt_lvl;
  logic [1:0] nxt_txa, nxt_txb, nxt_rx;
  logic       power_ff, tx_ff, clkpin_ff, txgate_ff, amp_ff, wake_ff;
  logic       lna_ff, route_ff, disc_ff, xtal_ff, bw_ff, sref_ff;
  logic [2:0] lvl_ff;
  logic [1:0] txa_ff, txb_ff, rx_ff;

  always_comb begin
    pwr       = ctrl_ff[POS_PWR];
    dir       = ctrl_ff[POS_DIR];
    lock_only = ctrl_ff[POS_LOCK];
    meas_sel  = ctrl_ff[POS_MEAS];
    nxt_power = pwr;
    nxt_tx = dir;
    nxt_clkpin = ctrl_ff[POS_CLK] & pwr & recovered_clk_in;
    nxt_txgate = pwr & dir & (~lock_only | synth_lock_flag);
    nxt_amp = ctrl_ff[POS_AMP] & pwr;
    nxt_wake = ctrl_ff[POS_WAKE];
    nxt_lna = ctrl_ff[POS_LNA];
    nxt_route = meas_sel & pwr;
    nxt_disc = ctrl_ff[POS_ADCS];
    nxt_lvl = 3'(fld(ctrl_ff, POS_LVL, WID_LVL));
    nxt_txa = ctrl_ff[POS_TRANSMIT_FREQ_PAIR_SELECT] ? PAIR_HI_A : PAIR_LO_A;
    nxt_txb = ctrl_ff[POS_TRANSMIT_FREQ_PAIR_SELECT] ? PAIR_HI_B : PAIR_LO_B;
    nxt_rx = 2'(fld(ctrl_ff, POS_RECEIVE_FREQ_SELECT, WID_RECEIVE_FREQ_SELECT));
    nxt_xtal = ctrl_ff[POS_XTAL];
    nxt_bw = ctrl_ff[POS_BW];
    nxt_sref = ctrl_ff[POS_SREF];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_ff <= 1'b0;  tx_ff <= 1'b0;  clkpin_ff <= 1'b0;  txgate_ff <= 1'b0;
      amp_ff <= 1'b0;  wake_ff <= 1'b0;  lna_ff <= 1'b0;  route_ff <= 1'b0;
      disc_ff <= 1'b0;  lvl_ff <= '0;  txa_ff <= PAIR_LO_A;  txb_ff <= PAIR_LO_B;
      rx_ff <= PAIR_HI_A;  xtal_ff <= 1'b0;  bw_ff <= 1'b1;  sref_ff <= 1'b1;
    end else if (ce) begin
      power_ff <= nxt_power;  tx_ff <= nxt_tx;  clkpin_ff <= nxt_clkpin;
      txgate_ff <= nxt_txgate;  amp_ff <= nxt_amp;  wake_ff <= nxt_wake;
      lna_ff <= nxt_lna;  route_ff <= nxt_route;  disc_ff <= nxt_disc;
      lvl_ff <= nxt_lvl;  txa_ff <= nxt_txa;  txb_ff <= nxt_txb;  rx_ff <= nxt_rx;
      xtal_ff <= nxt_xtal;  bw_ff <= nxt_bw;  sref_ff <= nxt_sref;
    end
  end

  assign power_on               = power_ff;
  assign tx_mode                = tx_ff;
  assign recovered_clk_pin      = clkpin_ff;
  assign transmit_gate          = txgate_ff;
  assign amp_on                 = amp_ff;
  assign wakeup_run             = wake_ff;
  assign lna_min_gain           = lna_ff;
  assign adc_supply_route       = route_ff;
  assign adc_disc_source        = disc_ff;
  assign output_power_level     = lvl_ff;
  assign tx_freq_code_a         = txa_ff;
  assign tx_freq_code_b         = txb_ff;
  assign rx_freq_code           = rx_ff;
  assign crystal_high           = xtal_ff;
  assign discriminator_standard = bw_ff;
  assign slicer_internal        = sref_ff;

  // ----------------------------------------------------------------------
  // Measurement results
  // ----------------------------------------------------------------------
  logic [LVL_W-1:0] rssi_ff, nxt_rssi, vcc_ff, nxt_vcc;
  logic             rssi_stb;

  // Supply reads leave the data gate holding its state since the gate shares the level result strobe
  always_comb begin
    rssi_stb = adc_valid & ~meas_sel;
    nxt_rssi = rssi_stb ? adc_level : rssi_ff;
    nxt_vcc = (adc_valid & meas_sel & pwr) ? adc_level : vcc_ff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rssi_ff <= '0;
      vcc_ff <= '0;
    end else if (ce) begin
      rssi_ff <= nxt_rssi;
      vcc_ff <= nxt_vcc;
    end
  end

  assign measured_signal_level = rssi_ff;
  assign supply_level          = vcc_ff;

  // ----------------------------------------------------------------------
  // Demodulated data output
  // ----------------------------------------------------------------------
  logic gate_pass, demod_ff, nxt_demod;

  tmc_rssi_gate u_gate (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .meas_stb (rssi_stb),
    .level    (adc_level),
    .thr      (fld(ctrl_ff, POS_THR, WID_THR)),
    .hys      (3'(fld(ctrl_ff, POS_HYS, WID_HYS))),
    .pass     (gate_pass)
  );

  always_comb begin
    nxt_demod = pwr & ~dir & gate_pass & (ctrl_ff[POS_POL] ? demod_raw : ~demod_raw);
  end

  always_ff @(posedge clk) begin
    if (rst) demod_ff <= 1'b0;
    else if (ce) demod_ff <= nxt_demod;
  end

  assign demod_data_pin = demod_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write;
    ce && ser_bus.wr_stb;
  endsequence
  sequence s_run;
    ce;
  endsequence

  AST_PWR_RESET: assert property ($past(rst) |-> !power_on)
    else $error("powered after reset");
  AST_TX_DIR: assert property (s_write ##1 s_run |=> tx_mode == $past(ctrl_ff[POS_DIR]))
    else $error("direction not following written value");
  AST_CLKPIN: assert property ((ce && !ctrl_ff[POS_CLK]) |=> !recovered_clk_pin)
    else $error("clock pin active while disabled");
  AST_TXGATE: assert property (ce |=> transmit_gate ==
    $past(pwr & dir & (~lock_only | synth_lock_flag))) else $error("transmit gate wrong");
  AST_AMP: assert property (ce |=> amp_on == $past(ctrl_ff[POS_AMP] & pwr))
    else $error("amplifier state wrong");
  AST_RSSI_HOLD: assert property (meas_sel |=> $stable(measured_signal_level))
    else $error("level result moved during supply read");
  AST_NO_VCC_DOWN: assert property (!pwr |=> $stable(supply_level))
    else $error("supply read while powered down");
  AST_RESERVED: assert property ((ctrl_ff & ~CTRL_WRITABLE) == '0)
    else $error("reserved bit set");
  AST_RECEIVE_FREQ_SELECT: assert property (ce |=> rx_freq_code == $past(ctrl_ff[9:8]))
    else $error("receive code wrong");
  AST_WRITE_HOLD: assert property (!ser_bus.wr_stb |=> $stable(ctrl_ff))
    else $error("register changed without write");
endmodule // tmc_top
`default_nettype wire

// ==== verification/tmc_host_model.sv ====
// Host side of the three-wire serial link to the main control register.
// Assumes the bench calls frame() and feeds the wire level back to the device.
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
  input  wire logic clk,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      sle,
  output logic      sck,
  output logic      line
);
  localparam int P = 6;
  logic d    = 1'b0;
  logic drv  = 1'b1;
  logic flip = 1'b0;
  // Released line toggles so a stale value can never pass as data
  always @(negedge clk) flip <= ~flip;
  assign line = dev_oe ? dev_out : (drv ? d : flip);
  initial begin
    sle = 1'b1;
    sck = 1'b0;
  end
  task automatic hold();
    repeat (P) @(negedge clk);
  endtask
  // ---------------------------------------------------------------
  // Frame: address and R/W clocked on rise, data MSB first
  // ---------------------------------------------------------------
  // three wire frame
  task automatic frame(input logic [3:0] a, input logic rw, input logic [31:0] w,
                       input int n, output logic [31:0] q);
    q = 32'h0;
    drv = 1'b1;
    sle = 1'b0;
    hold();
    for (int i = 0; i < 5 + n; i++) begin
      if (i < 5 || rw) begin
        d = (i < 4) ? a[3-i] : ((i == 4) ? rw : w[36-i]);
      end
      hold();
      if (i >= 5 && !rw) q[36-i] = line;
      sck = 1'b1;
      hold();
      sck = 1'b0;
      if (i == 4) drv = rw;
    end
    hold();
    sle = 1'b1;
    drv = 1'b1;
    repeat (2) hold();
  endtask
endmodule // tmc_host_model
`default_nettype wire

// ==== verification/tb_transceiver_main_control_register.sv ====
// Self-checking bench of the main control register against a bench model.
// Assumes the host model drives the serial pins; other inputs come from here.
`timescale 1ns/1ps
`default_nettype none
module tb_transceiver_main_control_register;
  import tmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sle, sck, line, sdo, oe, lock, rclk, adc_v, raw;
  logic [5:0] adc_l, sig, sup, sig_m, sup_m;
  logic pwr, txm, rcp, tg, amp, wk, lna, sroute, dsrc, dpin, xh, dstd, sint;
  logic [2:0] lvl;
  logic [1:0] ta, tb, rxc;
  logic [31:0] m = CTRL_RESET;
  logic [31:0] seed = 32'hd8a4;
  logic pass_m = 1'b0;
  logic [5:0] hys_seq [10] = '{6'd27, 6'd32, 6'd35, 6'd36, 6'd35, 6'd32, 6'd29, 6'd28, 6'd27,
    6'd25};
  int miscompares = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  tmc_host_model tmc_host_model_inst (.clk(clk), .dev_out(sdo), .dev_oe(oe), .sle(sle),
    .sck(sck), .line(line));
  tmc_top tmc_top_inst (.clk(clk), .rst(rst), .ce(ce), .sle_pin(sle), .sck_pin(sck),
    .sdata_pin_in(line), .sdata_pin_out(sdo), .sdata_pin_oe(oe), .synth_lock_flag(lock),
    .recovered_clk_in(rclk), .adc_valid(adc_v), .adc_level(adc_l), .demod_raw(raw),
    .power_on(pwr), .tx_mode(txm), .recovered_clk_pin(rcp), .transmit_gate(tg),
    .amp_on(amp), .wakeup_run(wk), .lna_min_gain(lna), .adc_supply_route(sroute),
    .adc_disc_source(dsrc), .measured_signal_level(sig), .supply_level(sup),
    .demod_data_pin(dpin), .output_power_level(lvl), .tx_freq_code_a(ta),
    .tx_freq_code_b(tb), .rx_freq_code(rxc), .crystal_high(xh),
    .discriminator_standard(dstd), .slicer_internal(sint));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_dec();
    logic p;
    p = m[31];
    chk("mode", {p, m[30], p & m[30] & (~m[28] | lock), m[27] & p, m[26], m[25], m[24] & p,
      m[1], m[29] & p & rclk}, {pwr, txm, tg, amp, wk, lna, sroute, dsrc, rcp});
    chk("select", {m[14:12], m[11] ? 2'h2 : 2'h0, m[11] ? 2'h3 : 2'h1, m[9:8], m[7], m[6],
      m[4]}, {lvl, ta, tb, rxc, xh, dstd, sint});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] w, input int n);
    logic [31:0] mk;
    logic [31:0] q;
    mk = (n == 0) ? 32'h0 : ~(32'hffff_ffff >> n);
    if (a == ADDR_MAIN) m = (m & ~mk) | (w & mk & CTRL_WRITABLE);
    tmc_host_model_inst.frame(a, 1'b1, w, n, q);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    tmc_host_model_inst.frame(a, 1'b0, 32'h0, 32, q);
    chk("readback", e, q);
  endtask
  // Model of the hysteresis gate and the shared converter
  task automatic meas(input logic [5:0] v);
    int thr;
    int hys;
    thr = m[23:18];
    hys = m[17:15];
    seed = lfsr_next(seed);
    raw = seed[0];
    adc_l = v;
    if (!m[24]) begin
      sig_m = v;
      if (v >= thr + hys) pass_m = 1'b1;
      else if (v + hys < thr) pass_m = 1'b0;
    end else if (m[31]) begin
      sup_m = v;
    end
    @(negedge clk) adc_v = 1'b1;
    @(negedge clk) adc_v = 1'b0;
    repeat (4) @(negedge clk);
    chk("signal level", sig_m, sig);
    chk("supply level", sup_m, sup);
    chk("data pin", m[31] & ~m[30] & pass_m & ~(raw ^ m[5]), dpin);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {lock, rclk, adc_v, raw, adc_l, sig_m, sup_m} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_dec();
    rdchk(ADDR_MAIN, 32'h1000_0270);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      lock = seed[3];
      rclk = seed[9];
      // Host keeps reserved bits at 0
      // reserved written zero
      wr(ADDR_MAIN, (seed & 32'hffff_88f2) | (i[1:0] << 8) | ({3{i[0]}} << 12), 32);
      chk_dec();
      rdchk(ADDR_MAIN, m);
    end
    $display("test field decode done");
    wr(ADDR_MAIN, 32'hffff_ffff, 32);
    rdchk(ADDR_MAIN, m);
    wr(ADDR_MAIN, 32'h4000_0000, 2);
    wr(ADDR_MAIN, 32'h0, 0);
    rdchk(ADDR_MAIN, m);
    chk_dec();
    wr(4'h5, 32'h0, 32);
    rdchk(ADDR_MAIN, m);
    rdchk(4'h5, 32'hffff_ffff);
    $display("test partial and unmapped done");
    wr(ADDR_MAIN, 32'h8000_0020 | (32'd32 << 18) | (32'd4 << 15), 32);
    foreach (hys_seq[k]) begin
      meas(hys_seq[k]);
    end
    wr(ADDR_MAIN, m & ~32'h20, 32);
    meas(6'd40);
    $display("test hysteresis gate done");
    // Supply is measured whenever powered with the select bit set; the transmit direction bit is set too, so the data pin stays low
    // no supply read while powered down
    wr(ADDR_MAIN, m | 32'h4100_0000, 32);
    chk_dec();
    meas(6'd17);
    wr(ADDR_MAIN, m & 32'h7fff_ffff, 32);
    meas(6'd9);
    $display("test supply measure done");
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
endmodule // tb_transceiver_main_control_register
`default_nettype wire
